// ===== dmac_cfg.svh
// constants of the multiply-accumulate slice: widths, register map, field positions, resets
// assumes inclusion by bare name from the package and the design modules
//
// Summary of operation
// [RULE1] single-product mode adds operand x0 times y0 to the running sum
// [RULE2] output accumulator always present; input and pipeline stages each bypassable
// [RULE3] init input loads the start value instead of the previous sum
// [RULE4] overflow flag is registered on the same edge as the sum
// [RULE5] dual-product mode adds both products to the running sum in one step
// [RULE6] with dynamic operation the add/subtract input may change every cycle
// [RULE7] with dynamic operation an input picks parallel load or shift load
// [RULE8] each operand register loads from its port or the preceding cascade register
// [RULE9] accumulation runs at 9-bit or 18-bit operands, never at 36-bit
// [RULE10] the accumulate unit works on 54-bit values
// [RULE11] multipliers form half a 36x36, two 18x18 or four 9x9
// [RULE12] overflow sets when the signed sum leaves range, clears on init
// [RULE13] all stages hold while clock enable low and clear on reset
`ifndef DMAC_CFG_SVH
`define DMAC_CFG_SVH

// =========================================
// datapath widths
`define DMAC_OP_W 18
`define DMAC_ACC_W 54
`define DMAC_BUS_W 32

// =========================================
// register map, byte addresses
`define DMAC_ADDR_W 5
`define DMAC_REG_CTRL 5'h00
`define DMAC_REG_STATUS 5'h04
`define DMAC_REG_INT_STS 5'h08
`define DMAC_REG_INT_MASK 5'h0c
`define DMAC_REG_ACC_LO 5'h10
`define DMAC_REG_ACC_HI 5'h14

// =========================================
// control register fields
`define DMAC_CTRL_W 9
`define DMAC_CTRL_MODE_LSB 0
`define DMAC_CTRL_MODE_MSB 1
`define DMAC_CTRL_MCFG_LSB 2
`define DMAC_CTRL_MCFG_MSB 3
`define DMAC_CTRL_IN_EN 4
`define DMAC_CTRL_PIPE_EN 5
`define DMAC_CTRL_DYN 6
`define DMAC_CTRL_SUB 7
`define DMAC_CTRL_SHIFT 8
`define DMAC_CTRL_RESET 9'h035

// =========================================
// events and status
`define DMAC_EV_W 2
`define DMAC_EV_OVF 0
`define DMAC_EV_INIT 1
`define DMAC_EV_RESET 2'h0
`define DMAC_STATUS_OVF 0

`endif

// ===== dmac_pkg.sv
// types shared by the multiply-accumulate slice
// assumes dmac_cfg.svh sits in the include path
`include "dmac_cfg.svh"

package dmac_pkg;
   // accumulate modes
   typedef enum logic [1:0] {
      DMAC_MULT,
      DMAC_MAC,
      DMAC_DUAL_PRODUCT_ACCUMULATE
   } dmac_mode_e;

   // multiplier arrangement
   typedef enum logic [1:0] {
      DMAC_HALF36,
      DMAC_DUAL18,
      DMAC_QUAD9
   } dmac_mcfg_e;
endpackage

// ===== dmac_mult_if.sv
// operand and product bundle between the slice and its multiplier array
// assumes dmac_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dmac_cfg.svh"

interface dmac_mult_if import dmac_pkg::*; #(
   parameter int OP_W = `DMAC_OP_W
);
   logic signed [OP_W-1:0] x0;
   logic signed [OP_W-1:0] y0;
   logic signed [OP_W-1:0] x1;
   logic signed [OP_W-1:0] y1;
   dmac_mcfg_e cfg;
   logic signed [2*OP_W-1:0] p0;
   logic signed [2*OP_W-1:0] p1;
   logic signed [3*OP_W-1:0] wide;

   modport src (output x0, output y0, output x1, output y1, output cfg,
                input p0, input p1, input wide);
   modport mul (input x0, input y0, input x1, input y1, input cfg,
                output p0, output p1, output wide);
endinterface

`default_nettype wire

// ===== dmac_mult.sv
// combinational multiplier array of the slice
// assumes operands arrive signed; the caller registers the products
`timescale 1ns/1ps
`default_nettype none
`include "dmac_cfg.svh"

module dmac_mult import dmac_pkg::*; #(
   parameter int OP_W = `DMAC_OP_W
) (
   dmac_mult_if.mul m
);
   localparam int H = OP_W / 2;

   logic signed [2*H-1:0] lane [4];

   // =========================================
   // four narrow lanes
   genvar i;
   for (i = 0; i < 4; i++) begin : g_lane
      logic [OP_W-1:0] ax;
      logic [OP_W-1:0] by;
      assign ax = (i < 2) ? m.x0 : m.x1;
      assign by = (i < 2) ? m.y0 : m.y1;
      assign lane[i] = $signed(ax[(i%2)*H +: H]) * $signed(by[(i%2)*H +: H]);
   end

   // =========================================
   // arrangement select
   always_comb begin
      m.p0 = '0;
      m.p1 = '0;
      m.wide = '0;
      case (m.cfg)
         DMAC_DUAL18: begin // RULE11
            m.p0 = m.x0 * m.y0;
            m.p1 = m.x1 * m.y1;
         end
         DMAC_QUAD9: begin // RULE11
            m.p0 = {lane[1], lane[0]};
            m.p1 = {lane[3], lane[2]};
         end
         DMAC_HALF36: begin
            // upper half of a 36x36: 36-bit x times one 18-bit y
            m.wide = $signed({m.x1, m.x0}) * m.y0; // RULE11
         end
         default: begin
            m.p0 = '0;
         end
      endcase
   end
endmodule // dmac_mult

`default_nettype wire

// ===== dmac_slice.sv
// multiply-accumulate slice: operand stage, multipliers, pipeline stage, accumulator
// assumes one clock, synchronous active-low reset, Avalon-MM master for settings
`timescale 1ns/1ps
`default_nettype none
`include "dmac_cfg.svh"

module dmac_slice import dmac_pkg::*; #(
   parameter int OP_W = `DMAC_OP_W,
   parameter int ACC_W = `DMAC_ACC_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [`DMAC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`DMAC_BUS_W-1:0] avs_writedata,
   output logic [`DMAC_BUS_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic signed [OP_W-1:0] mult0_operand_x,
   input wire logic signed [OP_W-1:0] mult0_operand_y,
   input wire logic signed [OP_W-1:0] mult1_operand_x,
   input wire logic signed [OP_W-1:0] mult1_operand_y,
   input wire logic [OP_W-1:0] casc_x0_in,
   input wire logic [OP_W-1:0] casc_y0_in,
   input wire logic [OP_W-1:0] casc_x1_in,
   input wire logic [OP_W-1:0] casc_y1_in,
   output logic [OP_W-1:0] casc_x0_out,
   output logic [OP_W-1:0] casc_y0_out,
   output logic [OP_W-1:0] casc_x1_out,
   output logic [OP_W-1:0] casc_y1_out,
   input wire logic product_add_sub,
   input wire logic load_shift_sel,
   input wire logic acc_init,
   input wire logic signed [ACC_W-1:0] acc_start,
   output logic signed [ACC_W-1:0] acc_out,
   output logic acc_overflow,
   output logic irq
);
   localparam int EW = ACC_W + 2;
   localparam int H = OP_W / 2;

   // =========================================
   // settings
   logic [`DMAC_CTRL_W-1:0] ctrl;
   logic [`DMAC_EV_W-1:0] int_sts;
   logic [`DMAC_EV_W-1:0] int_mask;
   dmac_mode_e mode;
   dmac_mcfg_e mcfg;
   logic in_en;
   logic pipe_en;
   logic eff_sub;
   logic eff_shift;

   assign mode = dmac_mode_e'(ctrl[`DMAC_CTRL_MODE_MSB:`DMAC_CTRL_MODE_LSB]);
   assign mcfg = dmac_mcfg_e'(ctrl[`DMAC_CTRL_MCFG_MSB:`DMAC_CTRL_MCFG_LSB]);
   assign in_en = ctrl[`DMAC_CTRL_IN_EN]; // RULE2
   assign pipe_en = ctrl[`DMAC_CTRL_PIPE_EN]; // RULE2
   // dynamic operation hands add/sub and load method to the fabric
   assign eff_sub = ctrl[`DMAC_CTRL_DYN] ? product_add_sub : ctrl[`DMAC_CTRL_SUB]; // RULE6
   assign eff_shift = ctrl[`DMAC_CTRL_DYN] ? load_shift_sel : ctrl[`DMAC_CTRL_SHIFT]; // RULE7

   // =========================================
   // bus slave: one wait cycle for every access
   logic wr_go;
   logic [`DMAC_BUS_W-1:0] rd_mux;
   logic [63:0] acc64;
   logic [`DMAC_CTRL_W-1:0] next_ctrl;
   logic [`DMAC_EV_W-1:0] ev;
   logic [`DMAC_EV_W-1:0] clr;

   assign wr_go = ce && avs_write && !avs_waitrequest;
   assign acc64 = 64'(acc_out);

   always_comb begin
      rd_mux = '0;
      case (avs_address)
         `DMAC_REG_CTRL: rd_mux = 32'(ctrl);
         `DMAC_REG_STATUS: rd_mux[`DMAC_STATUS_OVF] = acc_overflow;
         `DMAC_REG_INT_STS: rd_mux = 32'(int_sts);
         `DMAC_REG_INT_MASK: rd_mux = 32'(int_mask);
         `DMAC_REG_ACC_LO: rd_mux = acc64[31:0];
         `DMAC_REG_ACC_HI: rd_mux = acc64[63:32];
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else if (ce) begin
         if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
         end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
         end
      end
   end

   always_comb begin
      next_ctrl = avs_writedata[`DMAC_CTRL_W-1:0];
      // wide operands cannot accumulate; fall back to two medium multipliers
      if (next_ctrl[`DMAC_CTRL_MODE_MSB:`DMAC_CTRL_MODE_LSB] != DMAC_MULT &&
          next_ctrl[`DMAC_CTRL_MCFG_MSB:`DMAC_CTRL_MCFG_LSB] == DMAC_HALF36) begin // RULE9
         next_ctrl[`DMAC_CTRL_MCFG_MSB:`DMAC_CTRL_MCFG_LSB] = DMAC_DUAL18;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl <= `DMAC_CTRL_RESET;
         int_mask <= '0;
      end else if (wr_go) begin
         if (avs_address == `DMAC_REG_CTRL) begin
            ctrl <= next_ctrl;
         end
         if (avs_address == `DMAC_REG_INT_MASK) begin
            int_mask <= avs_writedata[`DMAC_EV_W-1:0];
         end
      end
   end

   assign clr = (wr_go && avs_address == `DMAC_REG_INT_STS) ?
                avs_writedata[`DMAC_EV_W-1:0] : '0;

   // a new event outranks a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         int_sts <= `DMAC_EV_RESET;
         irq <= 1'b0;
      end else if (ce) begin
         int_sts <= (int_sts & ~clr) | ev;
         irq <= |(int_sts & int_mask);
      end
   end

   // =========================================
   // operand stage with cascade shift
   logic [OP_W-1:0] op_port [4];
   logic [OP_W-1:0] op_casc [4];
   logic [OP_W-1:0] op_q [4];
   logic [OP_W-1:0] op_a [4];

   assign op_port[0] = mult0_operand_x;
   assign op_port[1] = mult0_operand_y;
   assign op_port[2] = mult1_operand_x;
   assign op_port[3] = mult1_operand_y;
   assign op_casc[0] = casc_x0_in;
   assign op_casc[1] = casc_y0_in;
   assign op_casc[2] = casc_x1_in;
   assign op_casc[3] = casc_y1_in;

   genvar i;
   for (i = 0; i < 4; i++) begin : g_op
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            op_q[i] <= '0; // RULE13
         end else if (ce) begin
            op_q[i] <= eff_shift ? op_casc[i] : op_port[i]; // RULE8
         end
      end
      // bypassed stage feeds the port straight through
      assign op_a[i] = in_en ? op_q[i] : op_port[i]; // RULE2
   end

   assign casc_x0_out = op_q[0];
   assign casc_y0_out = op_q[1];
   assign casc_x1_out = op_q[2];
   assign casc_y1_out = op_q[3];

   // controls travel with their operands so each product meets its own op
   logic sub_q;
   logic init_q;
   logic signed [ACC_W-1:0] start_q;
   logic sub_a;
   logic init_a;
   logic signed [ACC_W-1:0] start_a;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sub_q <= 1'b0;
         init_q <= 1'b0;
         start_q <= '0;
      end else if (ce) begin
         sub_q <= eff_sub;
         init_q <= acc_init;
         start_q <= acc_start;
      end
   end

   assign sub_a = in_en ? sub_q : eff_sub;
   assign init_a = in_en ? init_q : acc_init;
   assign start_a = in_en ? start_q : acc_start;

   // =========================================
   // multipliers
   dmac_mult_if #(.OP_W(OP_W)) mif ();

   assign mif.x0 = op_a[0];
   assign mif.y0 = op_a[1];
   assign mif.x1 = op_a[2];
   assign mif.y1 = op_a[3];
   assign mif.cfg = mcfg;

   dmac_mult #(.OP_W(OP_W)) u_mult (
      .m(mif.mul)
   );

   // =========================================
   // pipeline stage
   logic signed [2*OP_W-1:0] p0_q;
   logic signed [2*OP_W-1:0] p1_q;
   logic signed [3*OP_W-1:0] wide_q;
   logic sub_pq;
   logic init_pq;
   logic signed [ACC_W-1:0] start_pq;
   logic signed [2*OP_W-1:0] p0_b;
   logic signed [2*OP_W-1:0] p1_b;
   logic signed [3*OP_W-1:0] wide_b;
   logic sub_b;
   logic init_b;
   logic signed [ACC_W-1:0] start_b;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         p0_q <= '0;
         p1_q <= '0;
         wide_q <= '0;
         sub_pq <= 1'b0;
         init_pq <= 1'b0;
         start_pq <= '0;
      end else if (ce) begin
         p0_q <= mif.p0;
         p1_q <= mif.p1;
         wide_q <= mif.wide;
         sub_pq <= sub_a;
         init_pq <= init_a;
         start_pq <= start_a;
      end
   end

   assign p0_b = pipe_en ? p0_q : mif.p0; // RULE2
   assign p1_b = pipe_en ? p1_q : mif.p1;
   assign wide_b = pipe_en ? wide_q : mif.wide;
   assign sub_b = pipe_en ? sub_pq : sub_a;
   assign init_b = pipe_en ? init_pq : init_a;
   assign start_b = pipe_en ? start_pq : start_a;

   // =========================================
   // accumulator, two guard bits above the 54-bit value
   logic signed [EW-1:0] t0;
   logic signed [EW-1:0] t1;
   logic signed [EW-1:0] term;
   logic signed [EW-1:0] base;
   logic signed [EW-1:0] sum;
   logic ovf_now;
   logic signed [ACC_W-1:0] next_acc;
   logic next_ovf;

   always_comb begin
      if (mcfg == DMAC_QUAD9) begin // RULE9
         t0 = EW'($signed(p0_b[2*H-1:0]));
         t1 = EW'($signed(p1_b[2*H-1:0]));
      end else begin
         t0 = EW'(p0_b);
         t1 = EW'(p1_b);
      end
      term = (mode == DMAC_DUAL_PRODUCT_ACCUMULATE) ? t0 + t1 : t0; // RULE1 RULE5
      base = init_b ? EW'(start_b) : EW'(acc_out); // RULE3
      sum = sub_b ? base - term : base + term; // RULE6 RULE10
      ovf_now = !(&sum[EW-1:ACC_W-1] || !(|sum[EW-1:ACC_W-1])); // RULE12
   end

   always_comb begin
      next_acc = sum[ACC_W-1:0];
      next_ovf = ovf_now || (acc_overflow && !init_b); // RULE12
      if (mode == DMAC_MULT) begin
         next_ovf = 1'b0;
         case (mcfg)
            DMAC_HALF36: next_acc = ACC_W'(wide_b);
            DMAC_QUAD9: next_acc = ACC_W'({p1_b[2*H-1:0], p0_b});
            default: next_acc = ACC_W'(t0);
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         acc_out <= '0; // RULE13
         acc_overflow <= 1'b0;
      end else if (ce) begin
         acc_out <= next_acc; // RULE2
         acc_overflow <= next_ovf; // RULE4
      end
   end

   // the interrupt flag fires only on the cycle the overflow first appears
   assign ev[`DMAC_EV_OVF] = ce && next_ovf && !acc_overflow;
   assign ev[`DMAC_EV_INIT] = ce && init_b && mode != DMAC_MULT;

   // =========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (ce ##0 s_req_wait ##1 ce |-> s_answer)
      else $error("bus answer not one cycle");
   a_acc_mac_add: assert property (ce && mode == DMAC_MAC && !init_b && !sub_b // RULE1
      |=> acc_out == $past(acc_out) + $past(ACC_W'(t0)))
      else $error("single product not added");
   a_acc_dual_sub: assert property (ce && mode == DMAC_DUAL_PRODUCT_ACCUMULATE && !init_b && sub_b // RULE5
      |=> acc_out == $past(acc_out) - $past(ACC_W'(t0 + t1)))
      else $error("dual product not subtracted");
   a_init_start: assert property (ce && mode != DMAC_MULT && init_b && !sub_b // RULE3
      |=> acc_out == $past(start_b) + $past(ACC_W'(term)))
      else $error("init did not load start value");
   a_ovf_clear: assert property (ce && init_b && !ovf_now |=> !acc_overflow) // RULE12
      else $error("overflow not cleared on init");
   a_ovf_sticky: assert property (acc_overflow && ce && !init_b |=> acc_overflow) // RULE12
      else $error("overflow dropped early");
   a_hold_no_ce: assert property (!ce |=> $stable(acc_out) && $stable(acc_overflow) // RULE13
      && $stable(op_q[0]))
      else $error("state moved with enable low");
   a_shift_load: assert property (ce && eff_shift |=> op_q[0] == $past(casc_x0_in)) // RULE8
      else $error("cascade shift not loaded");
   a_dyn_sub: assert property (ce && ctrl[`DMAC_CTRL_DYN] && !in_en && !pipe_en // RULE6
      |-> sub_b == product_add_sub)
      else $error("dynamic add/sub not followed");
   a_no_wide_acc: assert property (mode != DMAC_MULT |-> mcfg != DMAC_HALF36) // RULE9
      else $error("wide operands in accumulate");
   // the default disable would mask this check exactly while reset is low
   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // RULE13
      !rst_b |=> acc_out == '0 && !acc_overflow)
      else $error("reset did not clear");
endmodule // dmac_slice

`default_nettype wire

// ===== dmac_fabric_model.sv
// fabric partner of the slice: drives operands and run-time controls, acts as preceding cascade
// assumes the bench calls step or idle from its main sequence; one call per rising edge
`timescale 1ns/1ps
`default_nettype none
`include "dmac_cfg.svh"

module dmac_fabric_model #(
   parameter int OP_W = `DMAC_OP_W,
   parameter int ACC_W = `DMAC_ACC_W
) (
   input wire logic clk,
   output logic signed [OP_W-1:0] x0,
   output logic signed [OP_W-1:0] y0,
   output logic signed [OP_W-1:0] x1,
   output logic signed [OP_W-1:0] y1,
   output logic [OP_W-1:0] cx0,
   output logic [OP_W-1:0] cy0,
   output logic [OP_W-1:0] cx1,
   output logic [OP_W-1:0] cy1,
   output logic add_sub,
   output logic shift_sel,
   output logic init,
   output logic signed [ACC_W-1:0] start
);
   // =========================================
   // idle state
   // zero operands keep the running sum still, as the slice adds every enabled cycle
   initial begin
      {x0, y0, x1, y1} = '0;
      {cx0, cy0, cx1, cy1} = '0;
      {add_sub, shift_sel, init} = 3'h0;
      start = '0;
   end

   // =========================================
   // one operand set per edge
   task automatic step(input logic signed [OP_W-1:0] a, input logic signed [OP_W-1:0] b,
                       input logic signed [OP_W-1:0] c, input logic signed [OP_W-1:0] d,
                       input logic sub, input logic sh, input logic ini,
                       input logic signed [ACC_W-1:0] s);
      @(posedge clk);
      x0 <= a;
      y0 <= b;
      x1 <= c;
      y1 <= d;
      add_sub <= sub;
      shift_sel <= sh;
      init <= ini;
      start <= s;
   endtask

   task automatic idle();
      step('0, '0, '0, '0, 1'h0, 1'h0, 1'h0, '0);
   endtask

   // preceding element's operand registers simply hold what they were given
   task automatic set_casc(input logic [OP_W-1:0] a, input logic [OP_W-1:0] b);
      @(posedge clk);
      cx0 <= a;
      cy0 <= b;
   endtask
endmodule // dmac_fabric_model

`default_nettype wire

// ===== tb_dsp_multiply_accumulate_slice.sv
// self-checking bench of the slice: Avalon-MM tasks and directed accumulate sequences
// assumes the package, interface, multiplier, slice and fabric model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dmac_cfg.svh"

module tb_dsp_multiply_accumulate_slice;
   localparam int OW = `DMAC_OP_W;
   localparam int AW = `DMAC_ACC_W;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic ce = 1'h1;
   logic [`DMAC_ADDR_W-1:0] addr = '0;
   logic rd_en = 1'h0;
   logic wr_en = 1'h0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic wait_req;
   logic signed [OW-1:0] x0, y0, x1, y1;
   logic [OW-1:0] cx0, cy0, cx1, cy1, ox0, oy0;
   logic add_sub, shift_sel, init, ovf, irq;
   logic signed [AW-1:0] start, acc;
   int errors = 0;
   int cmp_count = 0;

   always #2.5 clk = ~clk;

   dmac_slice i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(addr), .avs_read(rd_en),
      .avs_write(wr_en), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .mult0_operand_x(x0), .mult0_operand_y(y0),
      .mult1_operand_x(x1), .mult1_operand_y(y1), .casc_x0_in(cx0), .casc_y0_in(cy0),
      .casc_x1_in(cx1), .casc_y1_in(cy1), .casc_x0_out(ox0), .casc_y0_out(oy0),
      .casc_x1_out(), .casc_y1_out(), .product_add_sub(add_sub), .load_shift_sel(shift_sel),
      .acc_init(init), .acc_start(start), .acc_out(acc), .acc_overflow(ovf), .irq(irq));

   dmac_fabric_model i_fab (.clk(clk), .x0(x0), .y0(y0), .x1(x1), .y1(y1), .cx0(cx0),
      .cy0(cy0), .cx1(cx1), .cy1(cy1), .add_sub(add_sub), .shift_sel(shift_sel),
      .init(init), .start(start));

   // =========================================
   // reporting
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
   endtask

   task automatic chk_acc(input logic [AW-1:0] exp);
      cmp_count++;
      if (acc !== exp) fail($sformatf("sum %h expected %h", acc, exp));
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) fail($sformatf("%s is %b", what, got));
   endtask

   // =========================================
   // bus access
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      if (w) wr_en <= 1'h1;
      else rd_en <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'h0 && n < 40);
      rv = rdata;
      wr_en <= 1'h0;
      rd_en <= 1'h0;
      if (wait_req !== 1'h0) begin
         fail("bus timeout");
         give_verdict();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk_word(rv, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // =========================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(negedge clk);
      chk_acc(54'h0);
      chk_bit(ovf, 1'h0, "overflow");
      chk_bit(irq, 1'h0, "irq");
      rd_chk(5'h00, 32'h35);
      wr(5'h1c, 32'hffff_ffff);
      rd_chk(5'h1c, 32'h0);
      wr(5'h00, 32'h31);
      rd_chk(5'h00, 32'h35);
      i_fab.step(18'sh3, 18'sh5, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh64);
      i_fab.step(-18'sh7, 18'sh4, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(5);
      chk_acc(54'h57);
      // static subtract, init takes start minus product
      wr(5'h00, 32'hb5);
      i_fab.step(18'sh3, 18'sh5, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh64);
      i_fab.idle();
      settle(5);
      chk_acc(54'h55);
      wr(5'h00, 32'h75);
      i_fab.step(18'sh2, 18'sh3, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh0);
      i_fab.step(18'sh4, 18'sh5, 18'sh0, 18'sh0, 1'h1, 1'h0, 1'h0, 54'sh0);
      i_fab.step(18'sh1, 18'sh1, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(5);
      chk_acc(54'h3f_ffff_ffff_fff3);
      rd_chk(5'h10, 32'hffff_fff3);
      // high word carries the sign above bit 53
      rd_chk(5'h14, 32'hffff_ffff);
      i_fab.set_casc(18'h6, 18'h7);
      i_fab.step(18'sh64, 18'sh64, 18'sh0, 18'sh0, 1'h0, 1'h1, 1'h1, 54'sh0);
      i_fab.idle();
      @(negedge clk);
      chk_word({14'h0, ox0}, 32'h6);
      chk_word({14'h0, oy0}, 32'h7);
      settle(5);
      chk_acc(54'h2a);
      wr(5'h00, 32'h36);
      i_fab.step(18'sh2, 18'sh3, 18'sh4, 18'sh5, 1'h0, 1'h0, 1'h1, 54'sha);
      i_fab.step(-18'sh1, 18'sh1, 18'sh2, 18'sh2, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(5);
      chk_acc(54'h27);
      // both optional stages off, dynamic add/sub: one edge from ports to sum
      wr(5'h00, 32'h45);
      i_fab.step(18'sh2, 18'sh2, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh7);
      @(negedge clk);
      chk_acc(54'h27);
      i_fab.idle();
      @(negedge clk);
      chk_acc(54'hb);
      wr(5'h00, 32'h35);
      i_fab.step(18'sh3, 18'sh3, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh0);
      i_fab.idle();
      settle(1);
      chk_acc(54'hb);
      settle(1);
      chk_acc(54'h9);
      wr(5'h00, 32'h34);
      i_fab.step(18'sh3, 18'sh4, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.step(18'sh5, 18'sh6, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(2);
      chk_acc(54'h1e);
      // wide product: {x1, x0} times y0
      wr(5'h00, 32'h30);
      i_fab.step(18'sh2, 18'sh3, 18'sh1, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(2);
      chk_acc(54'hc_0006);
      // four narrow lanes, the low three packed side by side into the sum
      wr(5'h00, 32'h38);
      i_fab.step(18'sh403, 18'sh805, 18'sh6, 18'sh7, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      settle(2);
      chk_acc(54'h2a0_0020_000f);
      // overflow and interrupt: raise, mask, clear
      wr(5'h00, 32'h35);
      wr(5'h0c, 32'h1);
      wr(5'h08, 32'h3);
      i_fab.step(18'sh1, 18'sh1, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh1f_ffff_ffff_ffff);
      i_fab.idle();
      settle(1);
      chk_bit(ovf, 1'h0, "early overflow");
      settle(1);
      chk_acc(54'h20_0000_0000_0000);
      chk_bit(ovf, 1'h1, "overflow");
      settle(5);
      chk_bit(ovf, 1'h1, "sticky overflow");
      rd_chk(5'h04, 32'h1);
      rd_chk(5'h08, 32'h3);
      chk_bit(irq, 1'h1, "irq");
      wr(5'h0c, 32'h0);
      settle(2);
      chk_bit(irq, 1'h0, "masked irq");
      wr(5'h08, 32'h1);
      rd_chk(5'h08, 32'h2);
      wr(5'h0c, 32'h2);
      settle(2);
      chk_bit(irq, 1'h1, "init irq");
      wr(5'h08, 32'h2);
      settle(2);
      chk_bit(irq, 1'h0, "cleared irq");
      i_fab.step(18'sh0, 18'sh0, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h1, 54'sh0);
      i_fab.idle();
      settle(5);
      chk_bit(ovf, 1'h0, "overflow after init");
      // clock enable low freezes a product in flight
      i_fab.step(18'sh5, 18'sh5, 18'sh0, 18'sh0, 1'h0, 1'h0, 1'h0, 54'sh0);
      i_fab.idle();
      ce <= 1'h0;
      settle(4);
      chk_acc(54'h0);
      @(posedge clk);
      ce <= 1'h1;
      settle(5);
      chk_acc(54'h19);
      @(posedge clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      @(negedge clk);
      chk_acc(54'h0);
      give_verdict();
   end
endmodule // tb_dsp_multiply_accumulate_slice

`default_nettype wire
